// File: hw/usbim_pkg.sv
// Package of register map, field layout and carriers for the USB interface machine status block.
package usbim_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_RESET   = 8'h00;
   localparam logic [7:0] OFS_ADDR    = 8'h08;
   localparam logic [7:0] OFS_OTG     = 8'h14;
   localparam logic [7:0] OFS_SER     = 8'h18;
   localparam logic [7:0] OFS_FLAGS   = 8'h1c;
   localparam logic [7:0] OFS_STICKY  = 8'h20;
   localparam logic [7:0] OFS_MASK    = 8'h24;
   localparam logic [7:0] OFS_SOF     = 8'h28;
   localparam logic [7:0] OFS_PID     = 8'h2c;
   localparam logic [7:0] OFS_EP      = 8'h30;
   localparam logic [7:0] OFS_MARK    = 8'h34;
   localparam logic [7:0] OFS_OTGMASK = 8'h38;
   localparam logic [7:0] OFS_PWR     = 8'h3c;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int         SER_SE0_BIT  = 3;
   localparam int         SER_DAT_BIT  = 2;
   localparam int         SER_TXEN_BIT = 1;
   localparam int         SER_FSLS_BIT = 0;
   localparam logic [3:0] SER_RST      = 4'h2;
   localparam int         NFLAGS       = 7;
   localparam int         FL_TOKEN     = 6;
   localparam int         FL_SE0       = 5;
   localparam int         FL_K         = 4;
   localparam int         FL_J         = 3;
   localparam int         FL_CRC       = 2;
   localparam int         FL_RXACT     = 1;
   localparam int         FL_RXERR     = 0;
   localparam logic [6:0] FL_LEVEL     = 7'h3b;
   localparam int         MASK_W       = 8;
   localparam int         SOF_W        = 11;
   localparam int         EP_VALID_BIT = 4;
   localparam logic [4:0] EP_MARK_OR   = 5'h10;
   localparam int         PWR_W        = 9;
   localparam logic [1:0] LS_SE0       = 2'h0;
   localparam logic [1:0] LS_J         = 2'h1;
   localparam logic [1:0] LS_K         = 2'h2;
   typedef struct packed {
      logic b_sess;
      logic id_gnd;
      logic host_dis;
      logic vbus_vld;
      logic sess_vld;
      logic sess_end;
   } usbim_otg_s;
   typedef struct packed {
      logic [3:0] pid;
      logic [6:0] addr;
      logic [3:0] endp;
      logic       has_ep;
   } usbim_tok_s;
endpackage

// File: hw/usbim_status_regs.sv
// Status and control register logic of the USB interface machine.
// Overview of operation
// - OTG status register mirrors six transceiver session indications, bits 5 to 0.
// - Serial bits 6..4 read differential, minus and plus line receive; read-only, not reset.
// - Serial bits 3 and 2 are writable, reset 0, drive SE0 and transmit data.
// - Serial bit 1 resets to 1; writing 0 enables the serial transmitter.
// - Serial bit 0 selects full/low-speed serial mode; resets to 0.
// - Non-sticky flags 6 and 2 clear on the next packet; other non-sticky flags follow their signals.
// - Flag 6 sets on a good token carrying our device address.
// - Flags 5, 4, 3 set on line state SE0, K and J.
// - Flag 2 sets when a data packet fails its CRC16 check.
// - Flags 1 and 0 follow receive-active and receive-error inputs.
// - Seven stickiness bits; sticky flag holds until software writes 1 to it.
// - Four 8-bit masks drive four notify ports high when any selected flag is high.
// - Frame counter is 11 bits, reset 0, software writable, high bits at 10:8.
// - Last packet identifier captured into read-only bits 3:0.
// - Last endpoint captured into bits 3:0; bit 4 marks it valid.
// - Marked endpoints are delivered on the receive port ORed with 0x10.
// - Any write to the reset register resets all interface state.
// - Only tokens for the programmed 7-bit device address pass on.
`timescale 1ns/100ps
`default_nettype none
module usbim_status_regs
   import usbim_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   output logic             reg_rvalid,
   // Transceiver pins
   input  wire usbim_otg_s  otg_in,
   input  wire logic        rx_rcv_in,
   input  wire logic        rx_dm_in,
   input  wire logic        rx_dp_in,
   input  wire logic [1:0]  line_state_in,
   input  wire logic        rx_active_in,
   input  wire logic        rx_error_in,
   output logic             tx_se0,
   output logic             tx_dat,
   output logic             tx_enable_n,
   output logic             fsls_serial,
   // Packet decoder
   input  wire logic        pkt_start,
   input  wire logic        tok_valid,
   input  wire usbim_tok_s  tok,
   input  wire logic        crc16_fail,
   input  wire logic        sof_valid,
   input  wire logic [10:0] sof_frame,
   // Notify and receive ports
   output logic [3:0]       notify,
   output logic             rx_ep_valid,
   output logic [4:0]       rx_ep_data
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int SYN_W = 13;
   logic [SYN_W-1:0] syn1_q;
   logic [SYN_W-1:0] syn2_q;
   always_ff @(posedge clock) begin
      syn1_q <= {otg_in, rx_rcv_in, rx_dm_in, rx_dp_in, line_state_in, rx_active_in, rx_error_in};
      syn2_q <= syn1_q;
   end
   usbim_otg_s otg_s;
   logic [2:0] rxl_s;
   logic [1:0] ls_s;
   // Packing: session levels 12:7, receive lines 6:4, line state 3:2, active 1, error 0.
   assign otg_s = usbim_otg_s'(syn2_q[12:7]);
   assign rxl_s = syn2_q[6:4];
   assign ls_s  = syn2_q[3:2];

   // ****************************************
   // Register state
   // ****************************************
   logic               rst_all;
   logic               wr_ser;
   logic               wr_flags;
   logic [6:0]         addr_q;
   logic [3:0]         ser_q;
   logic [NFLAGS-1:0]  flags_q;
   logic [NFLAGS-1:0]  sticky_q;
   logic [31:0]        mask_q;
   logic [SOF_W-1:0]   sof_q;
   logic [3:0]         pid_q;
   logic [4:0]         ep_q;
   logic [15:0]        mark_q;
   logic [31:0]        otgm_q;
   logic [PWR_W-1:0]   pwr_q;
   logic               tok_ok;
   logic [NFLAGS-1:0]  ev;
   logic [NFLAGS-1:0]  clr;

   // Software reset acts on the edge that ends the write, like the pin reset.
   assign rst_all  = sys_rst | (reg_wr & (reg_addr == OFS_RESET));
   assign wr_ser   = reg_wr & (reg_addr == OFS_SER);
   assign wr_flags = reg_wr & (reg_addr == OFS_FLAGS);
   assign tok_ok   = tok_valid & (tok.addr == addr_q);

   always_ff @(posedge clock) begin
      if (rst_all) begin
         addr_q   <= '0;
         sticky_q <= '0;
         mask_q   <= '0;
         mark_q   <= '0;
         otgm_q   <= '0;
         pwr_q    <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            OFS_ADDR:    addr_q   <= reg_wdata[6:0];
            OFS_STICKY:  sticky_q <= reg_wdata[NFLAGS-1:0];
            OFS_MASK:    mask_q   <= reg_wdata;
            OFS_MARK:    mark_q   <= reg_wdata[15:0];
            OFS_OTGMASK: otgm_q   <= reg_wdata;
            OFS_PWR:     pwr_q    <= reg_wdata[PWR_W-1:0];
            default:     addr_q   <= addr_q;
         endcase
      end
   end

   // ****************************************
   // Serial drive
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst_all) begin
         ser_q <= SER_RST;
      end else if (wr_ser) begin
         ser_q <= reg_wdata[3:0];
      end
   end
   always_ff @(posedge clock) begin
      if (rst_all) begin
         tx_se0      <= SER_RST[SER_SE0_BIT];
         tx_dat      <= SER_RST[SER_DAT_BIT];
         tx_enable_n <= SER_RST[SER_TXEN_BIT];
         fsls_serial <= SER_RST[SER_FSLS_BIT];
      end else begin
         tx_se0      <= ser_q[SER_SE0_BIT];
         tx_dat      <= ser_q[SER_DAT_BIT];
         tx_enable_n <= ser_q[SER_TXEN_BIT];
         fsls_serial <= ser_q[SER_FSLS_BIT];
      end
   end

   // ****************************************
   // Signal flags
   // ****************************************
   always_comb begin
      ev           = '0;
      ev[FL_TOKEN] = tok_ok;
      ev[FL_SE0]   = (ls_s == LS_SE0);
      ev[FL_K]     = (ls_s == LS_K);
      ev[FL_J]     = (ls_s == LS_J);
      ev[FL_CRC]   = crc16_fail;
      ev[FL_RXACT] = syn2_q[1];
      ev[FL_RXERR] = syn2_q[0];
   end
   assign clr = wr_flags ? reg_wdata[NFLAGS-1:0] : '0;

   // A new event wins over a clear in the same cycle. Level flags that are
   // not sticky simply track their signal, so a packet start has no effect.
   for (genvar i = 0; i < NFLAGS; i++) begin : g_flag
      always_ff @(posedge clock) begin
         if (rst_all) begin
            flags_q[i] <= 1'b0;
         end else if (sticky_q[i]) begin
            flags_q[i] <= ev[i] | (flags_q[i] & ~clr[i]);
         end else if (FL_LEVEL[i]) begin
            flags_q[i] <= ev[i];
         end else begin
            flags_q[i] <= ev[i] | (flags_q[i] & ~clr[i] & ~pkt_start);
         end
      end
   end

   // ****************************************
   // Notify ports
   // ****************************************
   for (genvar p = 0; p < 4; p++) begin : g_port
      always_ff @(posedge clock) begin
         if (rst_all) begin
            notify[p] <= 1'b0;
         end else begin
            notify[p] <= |(mask_q[p*MASK_W +: NFLAGS] & flags_q);
         end
      end
   end

   // ****************************************
   // Frame counter, PID and endpoint capture
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst_all) begin
         sof_q <= '0;
      end else if (reg_wr && reg_addr == OFS_SOF) begin
         sof_q <= reg_wdata[SOF_W-1:0];
      end else if (sof_valid) begin
         sof_q <= sof_frame;
      end
   end
   always_ff @(posedge clock) begin
      if (rst_all) begin
         pid_q <= '0;
         ep_q  <= '0;
      end else if (tok_ok) begin
         pid_q <= tok.pid;
         if (tok.has_ep) begin
            ep_q <= {1'b1, tok.endp};
         end
      end
   end
   always_ff @(posedge clock) begin
      if (rst_all) begin
         rx_ep_valid <= 1'b0;
         rx_ep_data  <= '0;
      end else begin
         rx_ep_valid <= tok_ok & tok.has_ep;
         rx_ep_data  <= {1'b0, tok.endp} | (mark_q[tok.endp] ? EP_MARK_OR : 5'h00);
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   // Unmapped and write-only offsets read as zero.
   always_ff @(posedge clock) begin
      if (rst_all) begin
         reg_rvalid <= 1'b0;
         reg_rdata  <= '0;
      end else begin
         reg_rvalid <= reg_rd;
         case (reg_addr)
            OFS_ADDR:    reg_rdata <= {25'h0, addr_q};
            OFS_OTG:     reg_rdata <= {26'h0, otg_s};
            OFS_SER:     reg_rdata <= {25'h0, rxl_s, ser_q};
            OFS_FLAGS:   reg_rdata <= {25'h0, flags_q};
            OFS_STICKY:  reg_rdata <= {25'h0, sticky_q};
            OFS_MASK:    reg_rdata <= mask_q;
            OFS_SOF:     reg_rdata <= {21'h0, sof_q};
            OFS_PID:     reg_rdata <= {28'h0, pid_q};
            OFS_EP:      reg_rdata <= {27'h0, ep_q};
            OFS_MARK:    reg_rdata <= {16'h0, mark_q};
            OFS_OTGMASK: reg_rdata <= otgm_q;
            OFS_PWR:     reg_rdata <= {23'h0, pwr_q};
            default:     reg_rdata <= '0;
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst_all);

   otg_mirror_a: assert property (reg_rd && reg_addr == OFS_OTG
      |=> reg_rvalid && reg_rdata[5:0] == $past(otg_s))
      else $error("otg status read mismatch");
   ser_read_a: assert property (reg_rd && reg_addr == OFS_SER
      |=> reg_rdata[6:0] == {$past(rxl_s), $past(ser_q)})
      else $error("serial control read mismatch");
   ser_drive_a: assert property (wr_ser |-> ##2 {tx_se0, tx_dat, tx_enable_n, fsls_serial}
      == $past(reg_wdata[3:0], 2))
      else $error("serial write not driven");
   tok_flag_a: assert property (tok_valid && tok.addr == addr_q |=> flags_q[FL_TOKEN])
      else $error("token flag not set");
   foreign_tok_a: assert property (tok_valid && tok.addr != addr_q |=> !rx_ep_valid)
      else $error("foreign token passed on");
   line_flag_a: assert property (ls_s == LS_K && !sticky_q[FL_K] |=> flags_q[FL_K])
      else $error("K flag not set");
   crc_flag_a: assert property (crc16_fail |=> flags_q[FL_CRC])
      else $error("crc flag not set");
   rx_follow_a: assert property (!sticky_q[FL_RXACT] |=> flags_q[FL_RXACT] == $past(syn2_q[1]))
      else $error("rx active flag not following");
   packet_clear_a: assert property (pkt_start && !sticky_q[FL_CRC] && !crc16_fail
      |=> !flags_q[FL_CRC])
      else $error("flag not cleared by packet");
   sticky_hold_a: assert property (sticky_q[FL_CRC] && flags_q[FL_CRC] && !(wr_flags && reg_wdata[FL_CRC])
      |=> flags_q[FL_CRC])
      else $error("sticky flag lost");
   notify_route_a: assert property (|(mask_q[6:0] & flags_q) |=> notify[0])
      else $error("notify port 0 not raised");
   sof_load_a: assert property (reg_wr && reg_addr == OFS_SOF |=> sof_q == $past(reg_wdata[10:0]))
      else $error("frame counter write lost");
   ep_mark_a: assert property (tok_ok && tok.has_ep && mark_q[tok.endp]
      |=> rx_ep_valid && rx_ep_data == ({1'b0, $past(tok.endp)} | EP_MARK_OR))
      else $error("marked endpoint not flagged");
   ep_capture_a: assert property (tok_ok && tok.has_ep |=> ep_q == {1'b1, $past(tok.endp)})
      else $error("endpoint capture wrong");
   soft_reset_a: assert property (disable iff (sys_rst)
      reg_wr && reg_addr == OFS_RESET |=> ser_q == SER_RST && flags_q == '0)
      else $error("soft reset incomplete");

   token_seen_c: cover property (tok_ok && tok.has_ep ##1 rx_ep_valid);
   sticky_clear_c: cover property (sticky_q != '0 && wr_flags);
   notify_c: cover property (notify != '0);
   tx_enabled_c: cover property (!tx_enable_n);
endmodule
`default_nettype wire

// File: verif/usbim_phy_model.sv
// Behavioural transceiver and packet decoder facing the status block.
`timescale 1ns/100ps
`default_nettype none
module usbim_phy_model
   import usbim_pkg::*;
(
   // Serial drive from the block
   input  wire logic   clock,
   input  wire logic   tx_se0,
   input  wire logic   tx_dat,
   input  wire logic   tx_enable_n,
   // Levels towards the block
   output var usbim_otg_s otg,
   output logic        rcv,
   output logic        dm,
   output logic        dp,
   output var logic [1:0] ls,
   output var logic    act,
   output var logic    err,
   // Decoder pulses towards the block
   output var logic    pkt,
   output var logic    tok_v,
   output var usbim_tok_s tok,
   output var logic    crc_bad,
   output var logic    sof_v,
   output var logic [10:0] frame
);
   // ****************************************
   // Line loopback and decoder pulses
   // ****************************************
   // A released bus falls to its pull-downs, so nothing is read back while idle.
   always_comb begin
      dp = ~tx_enable_n & tx_dat & ~tx_se0;
      dm = ~tx_enable_n & ~tx_dat & ~tx_se0;
      rcv = dp;
   end
   initial begin
      {otg, act, err, pkt, tok_v, tok, crc_bad, sof_v, frame} = '0;
      // The line rests in the ignored state so that no line flag is raised at start.
      ls = 2'h3;
   end
   task automatic lines(input logic [5:0] o, input logic [3:0] s);
      @(posedge clock);
      #1;
      otg = o;
      {ls, act, err} = s;
      repeat (5) @(posedge clock);
      #1;
   endtask
   // Kinds: 0 packet start, 1 token, 2 data check failure, 3 frame start.
   task automatic pulse(input int k, input usbim_tok_s t, input logic [10:0] f);
      @(posedge clock);
      #1;
      tok = t;
      frame = f;
      case (k)
         0: pkt = 1'b1;
         1: tok_v = 1'b1;
         2: crc_bad = 1'b1;
         default: sof_v = 1'b1;
      endcase
      @(posedge clock);
      #1;
      {pkt, tok_v, crc_bad, sof_v} = '0;
      // Token and frame fields are not held once their strobe is gone.
      tok = ~t;
      frame = ~f;
   endtask
endmodule
`default_nettype wire

// File: verif/tb_usbim_status_regs.sv
// Self-checking bench for the USB interface machine status registers.
`timescale 1ns/100ps
`default_nettype none
module tb_usbim_status_regs;
   import usbim_pkg::*;
   logic        clock, sys_rst, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   usbim_otg_s  otg;
   usbim_tok_s  tok;
   logic        rcv, dm, dp, act, err, tx_se0, tx_dat, tx_enable_n, fsls;
   logic        pkt, tok_v, crc_bad, sof_v, ep_v;
   logic [1:0]  ls;
   logic [10:0] frame;
   logic [3:0]  notify;
   logic [4:0]  ep_d;
   int          error_cnt = 0, checks_done = 0, cyc = 0;
   logic [7:0]  ra [12] = '{OFS_OTG, OFS_SER, OFS_FLAGS, OFS_STICKY, OFS_MASK, OFS_SOF, OFS_PID, OFS_EP,
                            OFS_MARK, OFS_OTGMASK, OFS_PWR, 8'h44};
   logic [3:0]  lv [6] = '{4'h0, 4'h8, 4'h4, 4'hf, 4'hd, 4'hc};
   logic [7:0]  fe [6] = '{8'h20, 8'h10, 8'h08, 8'h03, 8'h01, 8'h00};
   logic [31:0] sw [3] = '{32'h5, 32'h8, 32'h6};
   logic [31:0] sp [3] = '{32'h0a0, 32'h100, 32'h0c0};
   logic [31:0] sr [3] = '{32'h55, 32'h08, 32'h06};
   usbim_status_regs uut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .otg_in(otg), .rx_rcv_in(rcv), .rx_dm_in(dm), .rx_dp_in(dp), .line_state_in(ls),
      .rx_active_in(act), .rx_error_in(err), .tx_se0(tx_se0), .tx_dat(tx_dat), .tx_enable_n(tx_enable_n),
      .fsls_serial(fsls), .pkt_start(pkt), .tok_valid(tok_v), .tok(tok), .crc16_fail(crc_bad),
      .sof_valid(sof_v), .sof_frame(frame), .notify(notify), .rx_ep_valid(ep_v), .rx_ep_data(ep_d));
   usbim_phy_model phy (.clock(clock), .tx_se0(tx_se0), .tx_dat(tx_dat), .tx_enable_n(tx_enable_n),
      .otg(otg), .rcv(rcv), .dm(dm), .dp(dp), .ls(ls), .act(act), .err(err), .pkt(pkt), .tok_v(tok_v),
      .tok(tok), .crc_bad(crc_bad), .sof_v(sof_v), .frame(frame));
   // ****************************************
   // Register access and checking
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      chk({31'h0, reg_rvalid}, 32'h1);
      chk(reg_rdata, e);
   endtask
   function automatic logic [31:0] pins();
      return {23'h0, tx_se0, tx_dat, tx_enable_n, fsls, notify, ep_v};
   endfunction
   task automatic reset_check();
      chk(pins(), 32'h040);
      for (int i = 0; i < 12; i++) begin
         rd(ra[i], (ra[i] == OFS_SER) ? {28'h0, SER_RST} : 32'h0);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
      repeat (5) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      reset_check();
      $display("test reset done");
      phy.lines(6'h2a, 4'hc);
      wr(OFS_OTG, 32'hffffffff);
      rd(OFS_OTG, 32'h2a);
      phy.lines(6'h15, 4'hc);
      rd(OFS_OTG, 32'h15);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_SER, sw[i]);
         repeat (3) @(posedge clock);
         #1;
         chk(pins(), sp[i]);
         rd(OFS_SER, sr[i]);
      end
      $display("test transceiver done");
      for (int i = 0; i < 6; i++) begin
         phy.lines(6'h0, lv[i]);
         rd(OFS_FLAGS, {24'h0, fe[i]});
      end
      wr(OFS_ADDR, 32'h5);
      wr(OFS_MARK, 32'h8);
      wr(OFS_MASK, 32'h40);
      phy.pulse(1, {4'h9, 7'h6, 4'h3, 1'b1}, 11'h0);
      chk({31'h0, ep_v}, 32'h0);
      rd(OFS_FLAGS, 32'h0);
      phy.pulse(1, {4'h9, 7'h5, 4'h3, 1'b1}, 11'h0);
      chk({26'h0, ep_v, ep_d}, 32'h33);
      rd(OFS_PID, 32'h9);
      rd(OFS_EP, 32'h13);
      rd(OFS_FLAGS, 32'h40);
      chk({28'h0, notify}, 32'h1);
      phy.pulse(1, {4'h1, 7'h5, 4'h2, 1'b1}, 11'h0);
      chk({26'h0, ep_v, ep_d}, 32'h22);
      phy.pulse(0, 16'h0, 11'h0);
      rd(OFS_FLAGS, 32'h0);
      chk({28'h0, notify}, 32'h0);
      $display("test token done");
      wr(OFS_STICKY, 32'h0c);
      wr(OFS_MASK, 32'h01020408);
      phy.pulse(2, 16'h0, 11'h0);
      phy.lines(6'h0, 4'h4);
      phy.lines(6'h0, 4'hc);
      phy.pulse(0, 16'h0, 11'h0);
      rd(OFS_FLAGS, 32'h0c);
      chk({28'h0, notify}, 32'h3);
      phy.lines(6'h0, 4'hf);
      chk({28'h0, notify}, 32'hf);
      wr(OFS_FLAGS, 32'h0c);
      rd(OFS_FLAGS, 32'h03);
      $display("test sticky done");
      phy.pulse(3, 16'h0, 11'h5a3);
      rd(OFS_SOF, 32'h5a3);
      wr(OFS_SOF, 32'hffffffff);
      rd(OFS_SOF, 32'h7ff);
      wr(OFS_OTGMASK, 32'hffffffff);
      rd(OFS_OTGMASK, 32'hffffffff);
      wr(OFS_PWR, 32'hffffffff);
      rd(OFS_PWR, 32'h1ff);
      wr(OFS_PID, 32'hffffffff);
      rd(OFS_PID, 32'h1);
      phy.lines(6'h0, 4'hc);
      wr(OFS_RESET, 32'h12345678);
      reset_check();
      rd(OFS_ADDR, 32'h0);
      $display("test soft reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
